// >>> inc/rpsl_pkg.sv
package rpsl_pkg;

    // Register map.
    localparam logic [7:0] STATUS_OFFSET = 8'h88;

    // Positions of the captured straps on the shared address/data pins.
    localparam int SPEED_LSB = 30;
    localparam int PLLRST_POS = 29;
    localparam int THRESH_POS = 28;
    localparam int LENGTH_LSB = 26;

    // The same straps sit at the same positions in the status word.
    localparam int STAT_SPEED_LSB = 30;
    localparam int STAT_PLLRST_POS = 29;
    localparam int STAT_THRESH_POS = 28;
    localparam int STAT_LENGTH_LSB = 26;

    // Reset value of the status register before any capture.
    localparam logic [31:0] STATUS_RESET = 32'h0000_0000;

    // Clock speed codes.
    typedef enum logic [1:0] {
        RPSL_SPEED_100 = 2'b00,
        RPSL_SPEED_66 = 2'b01,
        RPSL_SPEED_RSVD = 2'b10,
        RPSL_SPEED_133 = 2'b11
    } rpsl_speed_t;

    // Bus length codes.
    typedef enum logic [1:0] {
        RPSL_LEN_SHORT = 2'b00,
        RPSL_LEN_CLOSE = 2'b01,
        RPSL_LEN_FAR_DUAL = 2'b10,
        RPSL_LEN_FARTHEST = 2'b11
    } rpsl_length_t;

    // Captured strap bundle.
    typedef struct packed {
        rpsl_speed_t bus_clock_speed_select;
        logic pll_reset_high;
        logic clock_receiver_threshold_select;
        rpsl_length_t bus_length_class;
    } rpsl_straps_t;

    // Decoded operating parameters.
    typedef struct packed {
        logic speed_100;
        logic speed_66_test;
        logic speed_133;
        logic speed_reserved;
        logic pll_bypass_test;
        logic threshold_upper;
        rpsl_length_t bus_length_class;
    } rpsl_params_t;

endpackage : rpsl_pkg

// >>> rtl/rpsl_latch.sv
`timescale 1ns/100ps
`default_nettype none

module rpsl_latch (
    // Clock and reset.
    input wire logic i_clk_sys,
    input wire logic i_reset,
    // Shared address/data pins carrying the straps.
    input wire logic [31:0] i_ad_pins,
    // Register port.
    input wire logic [7:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_reg_write,
    input wire logic i_reg_read,
    output logic [31:0] o_reg_rdata,
    // Captured straps and decoded parameters.
    output rpsl_pkg::rpsl_straps_t o_straps,
    output rpsl_pkg::rpsl_params_t o_params,
    output logic o_straps_valid
);

    localparam int NSTRAP = 6;

    logic [NSTRAP-1:0] pins_raw;
    logic [NSTRAP-1:0] pins_sync;
    logic capture_open_r;
    logic capture_open_nxt;
    logic [2:0] rel_cnt_r;
    logic [2:0] rel_cnt_nxt;
    rpsl_pkg::rpsl_straps_t straps_r;
    rpsl_pkg::rpsl_straps_t straps_nxt;
    rpsl_pkg::rpsl_params_t params_r;
    rpsl_pkg::rpsl_params_t params_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [31:0] status_word;

    // Gather the strap pins; the rest of the bus is ordinary traffic.
    assign pins_raw = {
        i_ad_pins[rpsl_pkg::SPEED_LSB+1:rpsl_pkg::SPEED_LSB],
        i_ad_pins[rpsl_pkg::PLLRST_POS],
        i_ad_pins[rpsl_pkg::THRESH_POS],
        i_ad_pins[rpsl_pkg::LENGTH_LSB+1:rpsl_pkg::LENGTH_LSB]
    };

    // Pins are asynchronous to the core clock, so synchronise first.
    rpsl_sync #(
        .WIDTH(NSTRAP)
    ) u_sync (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_async(pins_raw),
        .o_sync(pins_sync)
    );

    // The capture window stays open one cycle past the synchroniser depth after
    // release, so the level sampled on the first edge after release is the one that sticks.
    // Async reset can only load constants, hence the clocked capture.
    always_comb begin
        capture_open_nxt = capture_open_r;
        rel_cnt_nxt = rel_cnt_r;
        straps_nxt = straps_r;
        if (capture_open_r) begin
            straps_nxt = rpsl_rpsl_cast(pins_sync);
            if (rel_cnt_r == 3'h2) begin
                capture_open_nxt = 1'b0;
            end else begin
                rel_cnt_nxt = rel_cnt_r + 3'h1;
            end
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            capture_open_r <= 1'b1;
            rel_cnt_r <= 3'h0;
            straps_r <= '0;
        end else begin
            capture_open_r <= capture_open_nxt;
            rel_cnt_r <= rel_cnt_nxt;
            straps_r <= straps_nxt;
        end
    end

    // Map the synchronised bits into the strap bundle.
    function automatic rpsl_pkg::rpsl_straps_t rpsl_rpsl_cast(
        input logic [NSTRAP-1:0] bits
    );
        rpsl_pkg::rpsl_straps_t s;
        s.bus_clock_speed_select = rpsl_pkg::rpsl_speed_t'(bits[5:4]);
        s.pll_reset_high = bits[3];
        s.clock_receiver_threshold_select = bits[2];
        s.bus_length_class = rpsl_pkg::rpsl_length_t'(bits[1:0]);
        return s;
    endfunction : rpsl_rpsl_cast

    // Decode straps into operating parameters.
    always_comb begin
        params_nxt = '0;
        case (straps_r.bus_clock_speed_select)
            rpsl_pkg::RPSL_SPEED_100: params_nxt.speed_100 = 1'b1;
            rpsl_pkg::RPSL_SPEED_66: params_nxt.speed_66_test = 1'b1;
            rpsl_pkg::RPSL_SPEED_133: params_nxt.speed_133 = 1'b1;
            default: params_nxt.speed_reserved = 1'b1;
        endcase
        // A low PLL reset strap means the board chose bypass test mode.
        params_nxt.pll_bypass_test = ~straps_r.pll_reset_high;
        // High enables the upper receiver range.
        params_nxt.threshold_upper =
            straps_r.clock_receiver_threshold_select;
        params_nxt.bus_length_class = straps_r.bus_length_class;
    end

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            params_r <= '0;
        end else begin
            params_r <= params_nxt;
        end
    end

    // Status word layout mirrors the strap pin positions.
    always_comb begin
        status_word = rpsl_pkg::STATUS_RESET;
        status_word[rpsl_pkg::STAT_SPEED_LSB+1:rpsl_pkg::STAT_SPEED_LSB] =
            straps_r.bus_clock_speed_select;
        status_word[rpsl_pkg::STAT_PLLRST_POS] = straps_r.pll_reset_high;
        status_word[rpsl_pkg::STAT_THRESH_POS] =
            straps_r.clock_receiver_threshold_select;
        status_word[rpsl_pkg::STAT_LENGTH_LSB+1:rpsl_pkg::STAT_LENGTH_LSB] =
            straps_r.bus_length_class;
    end

    // Read port; writes are ignored since the register is read-only.
    // Unmapped addresses read zero.
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (i_reg_read && i_reg_addr == rpsl_pkg::STATUS_OFFSET) begin
            rdata_nxt = status_word;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            rdata_r <= 32'h0000_0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign o_reg_rdata = rdata_r;
    assign o_straps = straps_r;
    assign o_params = params_r;
    assign o_straps_valid = ~capture_open_r;

endmodule : rpsl_latch

`default_nettype wire

// >>> rtl/rpsl_sync.sv
`timescale 1ns/100ps
`default_nettype none

// Two-flop synchroniser for asynchronous pin levels.
module rpsl_sync #(
    parameter int WIDTH = 6
) (
    // Clock and reset.
    input wire logic i_clk_sys,
    input wire logic i_reset,
    // Levels.
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    // The first stage feeds only the second stage.
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end

    assign o_sync = sync_r;

endmodule : rpsl_sync

`default_nettype wire

// >>> testbench/rpsl_checker.sv
`timescale 1ns/100ps
`default_nettype none
// Watches strap capture, decode and the status read port of the latch.
module rpsl_checker (
    // Clock and reset.
    input wire logic i_clk_sys,
    input wire logic i_reset,
    // Pins and register port.
    input wire logic [31:0] i_ad_pins,
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_read,
    input wire logic [31:0] o_reg_rdata,
    // Captured results.
    input wire rpsl_pkg::rpsl_straps_t o_straps,
    input wire rpsl_pkg::rpsl_params_t o_params,
    input wire logic o_straps_valid
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    // A status read is the strobe at the status offset once capture is over.
    sequence s_rd88;
        i_reg_read && i_reg_addr == 8'h88 && o_straps_valid;
    endsequence
    // Pins pass two sync flops, so the frozen value is three samples old.
    property p_cap;
        $rose(o_straps_valid) |-> o_straps == $past(i_ad_pins[31:26], 3);
    endproperty
    property p_hold;
        o_straps_valid |=> o_straps_valid && $stable(o_straps);
    endproperty
    property p_rd;
        s_rd88 |=> o_reg_rdata == {o_straps, 26'h0};
    endproperty
    property p_un;
        i_reg_read && i_reg_addr != 8'h88 |=> o_reg_rdata == 32'h0;
    endproperty
    property p_spd;
        o_straps_valid |=> o_params[7:4] == {o_straps[5:4] == 2'b00,
            o_straps[5:4] == 2'b01, o_straps[5:4] == 2'b11,
            o_straps[5:4] == 2'b10};
    endproperty
    property p_pll;
        o_straps_valid |=> o_params.pll_bypass_test != o_straps[3];
    endproperty
    property p_thr;
        o_straps_valid |=> o_params.threshold_upper == o_straps[2];
    endproperty
    property p_len;
        o_straps_valid |=> o_params.bus_length_class == o_straps[1:0];
    endproperty
    a_cap: assert property (p_cap) else $error("capture mismatch");
    a_hold: assert property (p_hold) else $error("straps moved");
    a_rd: assert property (p_rd) else $error("status read wrong");
    a_un: assert property (p_un) else $error("unmapped not zero");
    a_spd: assert property (p_spd) else $error("speed decode");
    a_pll: assert property (p_pll) else $error("pll decode");
    a_thr: assert property (p_thr) else $error("threshold decode");
    a_len: assert property (p_len) else $error("length decode");
endmodule : rpsl_checker
bind rpsl_latch rpsl_checker u_chk (.i_clk_sys, .i_reset, .i_ad_pins,
    .i_reg_addr, .i_reg_read, .o_reg_rdata, .o_straps, .o_params,
    .o_straps_valid);
`default_nettype wire

// >>> testbench/rpsl_pins_model.sv
`timescale 1ns/100ps
`default_nettype none
// Board resistors on the strap pins, then live bus traffic after capture.
module rpsl_pins_model (
    // Clock.
    input wire logic i_clk_sys,
    // Strap levels fitted on the board, and traffic on.
    input wire logic [5:0] i_strap,
    input wire logic i_traffic,
    // Shared pins.
    output logic [31:0] o_ad
);
    logic [31:0] pat_r = 32'h1;
    // Unpulled pins churn every cycle so a stale value cannot pass.
    always @(posedge i_clk_sys) pat_r <= pat_r * 32'h19660d + 32'h3c6ef35f;
    // Pin 29 carries a pull-up unless the bench picks bypass test.
    assign o_ad = i_traffic ? pat_r : {i_strap, pat_r[25:0]};
endmodule : rpsl_pins_model
`default_nettype wire

// >>> testbench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic i_clk_sys = 1'b0;
    logic i_reset = 1'b1;
    logic [7:0] i_reg_addr = 8'h0;
    logic [31:0] i_reg_wdata = 32'h0;
    logic i_reg_write = 1'b0;
    logic i_reg_read = 1'b0;
    logic [5:0] strap = 6'h20;
    logic traffic = 1'b0;
    logic [31:0] i_ad_pins, o_reg_rdata;
    rpsl_pkg::rpsl_straps_t o_straps;
    rpsl_pkg::rpsl_params_t o_params;
    logic o_straps_valid;
    integer seed = 32'h34a0;
    int n_fail = 0, num_checks = 0, cyc = 0;
    logic [31:0] exp_q[$];
    always #50 i_clk_sys = ~i_clk_sys;
    rpsl_pins_model u_pins (.i_clk_sys, .i_strap(strap), .i_traffic(traffic),
        .o_ad(i_ad_pins));
    rpsl_latch uut (.i_clk_sys, .i_reset, .i_ad_pins, .i_reg_addr,
        .i_reg_wdata, .i_reg_write, .i_reg_read, .o_reg_rdata, .o_straps,
        .o_params, .o_straps_valid);
    task chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            n_fail++;
            $display("unexpected t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task tally_and_finish();
        $display("checks=%0d fails=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish
    // Data stands only in the cycle after the strobe, so look just then.
    task rd(input logic [7:0] a, input logic [31:0] e);
        i_reg_addr <= a;
        i_reg_read <= 1'b1;
        @(posedge i_clk_sys);
        i_reg_read <= 1'b0;
        #1 chk(o_reg_rdata, e);
    endtask : rd
    // Cut a hang short; the run needs some 136 cycles.
    always @(posedge i_clk_sys) begin
        cyc++;
        if (cyc == 2000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    // Each pass fits new straps, resets, then reads under live traffic.
    initial begin
        logic [5:0] s;
        logic [7:0] e, ua;
        for (int i = 0; i < 8; i++) begin
            s = $random(seed);
            s = {i[1:0], i[2], s[0], ~i[1:0]};
            e = {s[5:4] == 2'b00, s[5:4] == 2'b01, s[5:4] == 2'b11,
                s[5:4] == 2'b10, !s[3], s[2], s[1:0]};
            exp_q.push_back({s, 26'h0});
            @(posedge i_clk_sys);
            traffic <= 1'b0;
            i_reset <= 1'b1;
            strap <= s;
            repeat (6) @(posedge i_clk_sys);
            chk({o_straps_valid, o_straps, o_params}, 32'h0);
            i_reset <= 1'b0;
            repeat (5) @(posedge i_clk_sys);
            traffic <= 1'b1;
            #1 chk(o_params, e);
            chk(o_straps_valid, 32'h1);
            i_reg_addr <= 8'h88;
            i_reg_wdata <= $random(seed);
            i_reg_write <= 1'b1;
            @(posedge i_clk_sys);
            i_reg_write <= 1'b0;
            ua = $random(seed);
            if (ua == 8'h88) ua = 8'h8c;
            #1 rd(8'h88, exp_q[0]);
            rd(ua, 32'h0);
            rd(8'h88, exp_q.pop_front());
            @(posedge i_clk_sys);
            #1 chk(o_reg_rdata, 32'h0);
        end
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
